// >>> rtl/dipn_map.svh
`ifndef DIPN_MAP_SVH
`define DIPN_MAP_SVH
// ****************************************
// frame identifiers
// ****************************************
`define DIPN_ID_NMT 11'h000
`define DIPN_ID_SYNC 11'h080
`define DIPN_ID_EMCY 11'h080
`define DIPN_ID_TPDO 11'h180
`define DIPN_ID_RPDO1 11'h200
`define DIPN_ID_RPDO2 11'h301
`define DIPN_ID_SDO_TX 11'h580
`define DIPN_ID_SDO_RX 11'h600
// ****************************************
// protocol codes
// ****************************************
`define DIPN_NMT_START 8'h01
`define DIPN_NMT_STOP 8'h02
`define DIPN_NMT_PREOP 8'h80
`define DIPN_SDO_WR1 8'h2F
`define DIPN_SDO_ACK 8'h60
`define DIPN_SDO_ABORT 8'h80
`define DIPN_ABORT_CODE 32'h0602_0000
`define DIPN_OBJ_MODE 16'h6060
`define DIPN_OBJ_IPTIME 16'h60C2
`define DIPN_SUB_0 8'h00
`define DIPN_SUB_1 8'h01
`define DIPN_SUB_2 8'h02
`define DIPN_MODE_IP 8'h07
`define DIPN_CW_SHUTDOWN 16'h0006
`define DIPN_CW_SWON 16'h0007
`define DIPN_CW_ENOP 16'h000F
`define DIPN_CW_ENIP 16'h001F
`define DIPN_CW_FRESET 16'h0080
`define DIPN_SW_DISABLED 16'h0250
`define DIPN_SW_READY 16'h0231
`define DIPN_SW_SWON 16'h0233
`define DIPN_SW_OPEN 16'h0237
`define DIPN_SW_IP 16'h1237
`define DIPN_SW_FAULT 16'h0218
`define DIPN_DLC_SW 4'h2
`define DIPN_DLC_FULL 4'h8
// ****************************************
// interpolation time exponents
// ****************************************
`define DIPN_EXP_MS 8'hFD
`define DIPN_EXP_100US 8'hFC
`define DIPN_EXP_10US 8'hFB
`define DIPN_EXP_US 8'hFA
`define DIPN_US_PER_MS 20'h003E8
`define DIPN_US_PER_100US 20'h00064
`define DIPN_US_PER_10US 20'h0000A
`define DIPN_UNIT_RST 8'h01
// ****************************************
// register map and reset values
// ****************************************
`define DIPN_REG_CTRL 8'h00
`define DIPN_REG_STAT 8'h04
`define DIPN_REG_IRQ 8'h08
`define DIPN_REG_MASK 8'h0C
`define DIPN_REG_SETP 8'h10
`define DIPN_REG_IPCYC 8'h14
`define DIPN_NODE_ID_RST 7'h01
`define DIPN_RESP_OKAY 2'h0
`define DIPN_RESP_SLVERR 2'h2
`endif

// >>> rtl/dipn_pkg.sv
package dipn_pkg;
  typedef enum logic [5:0] {
    ST_DISABLED = 6'h01,
    ST_READY = 6'h02,
    ST_SWON = 6'h04,
    ST_OPEN = 6'h08,
    ST_IP = 6'h10,
    ST_FAULT = 6'h20
  } dipn_state_t;
  typedef logic [3:0] dipn_irq_t;
endpackage

// >>> rtl/dipn_node.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dipn_map.svh"
// Function
// - mode object write 7, acknowledged
// - cycle from unit times ten power exponent
// - status word answers each control word
// - take own four-byte slot of setpoints
// - setpoint latched, applied on next sync in interpolation state
// - sync sends position and manufacturer status
// - fault sends emergency frame with code
// - every sync while operational processes and sends pdo
module dipn_node #(
  parameter logic [6:0] NODE_ID = `DIPN_NODE_ID_RST
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  output logic txValid,
  output logic [10:0] txId,
  output logic [3:0] txDlc,
  output logic [63:0] txData,
  input wire logic txReady,
  input wire logic [31:0] actualPos,
  input wire logic [31:0] mfrStatus,
  input wire logic [15:0] faultCode,
  input wire logic [7:0] errReg,
  output logic [31:0] targetPos,
  output logic stepStrobe,
  output logic ipActive,
  output logic irq
);
  // ****************************************
  // reset release
  // ****************************************
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  function automatic logic [15:0] swOf(input dipn_pkg::dipn_state_t s);
    case (s)
      dipn_pkg::ST_READY: swOf = `DIPN_SW_READY;
      dipn_pkg::ST_SWON: swOf = `DIPN_SW_SWON;
      dipn_pkg::ST_OPEN: swOf = `DIPN_SW_OPEN;
      dipn_pkg::ST_IP: swOf = `DIPN_SW_IP;
      dipn_pkg::ST_FAULT: swOf = `DIPN_SW_FAULT;
      default: swOf = `DIPN_SW_DISABLED;
    endcase
  endfunction

  // unsupported exponents give zero: cycle not usable
  function automatic logic [19:0] cycUs(input logic [7:0] u, input logic [7:0] e);
    case (e)
      `DIPN_EXP_MS: cycUs = 20'(u) * `DIPN_US_PER_MS;
      `DIPN_EXP_100US: cycUs = 20'(u) * `DIPN_US_PER_100US;
      `DIPN_EXP_10US: cycUs = 20'(u) * `DIPN_US_PER_10US;
      `DIPN_EXP_US: cycUs = 20'(u);
      default: cycUs = 20'h00000;
    endcase
  endfunction

  // ****************************************
  // register bus
  // ****************************************
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rdata_r, rdata_nxt, rdMux, wMask;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wrEn, wrHit, rdHit;
  // node state, read by the mux except ipUnit_r and ipExp_r
  logic [6:0] nodeId_r, nodeId_nxt;
  logic slot_r, slot_nxt, nmtOp_r, nmtOp_nxt;
  logic [7:0] mode_r, mode_nxt, ipUnit_r, ipUnit_nxt, ipExp_r, ipExp_nxt;
  logic [19:0] ipCycUs_r, ipCycUs_nxt;
  dipn_pkg::dipn_irq_t irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt, ev;
  dipn_pkg::dipn_state_t state_r, state_nxt;
  logic [31:0] targetPos_r, targetPos_nxt;

  always_comb begin
    wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
    wrHit = (awAddr_r == `DIPN_REG_CTRL) || (awAddr_r == `DIPN_REG_IRQ) ||
            (awAddr_r == `DIPN_REG_MASK);
    rdHit = 1'b1;
    case (s_axi_araddr)
      `DIPN_REG_CTRL: rdMux = {23'h000000, slot_r, 1'b0, nodeId_r};
      `DIPN_REG_STAT: rdMux = {mode_r, 7'h00, nmtOp_r, swOf(state_r)};
      `DIPN_REG_IRQ: rdMux = {28'h0000000, irqStat_r};
      `DIPN_REG_MASK: rdMux = {28'h0000000, irqMask_r};
      `DIPN_REG_SETP: rdMux = targetPos_r;
      `DIPN_REG_IPCYC: rdMux = {12'h000, ipCycUs_r};
      default: begin
        rdMux = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wrEn = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // one write in flight: no new address until the response is taken
    if (awHeld_r && wHeld_r && !bvalid_r) begin
      wrEn = 1'b1;
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wrHit ? `DIPN_RESP_OKAY : `DIPN_RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rdMux;
      rresp_nxt = rdHit ? `DIPN_RESP_OKAY : `DIPN_RESP_SLVERR;
    end
    awready_nxt = !awHeld_nxt && !bvalid_nxt;
    wready_nxt = !wHeld_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `DIPN_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `DIPN_RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ****************************************
  // node protocol
  // ****************************************
  logic setpPend_r, setpPend_nxt, sdoPend_r, sdoPend_nxt, stPend_r, stPend_nxt;
  logic pdoPend_r, pdoPend_nxt, emcyPend_r, emcyPend_nxt, sdoOk_r, sdoOk_nxt;
  logic txValid_r, txValid_nxt, step_r, step_nxt, ipAct_r, ipAct_nxt, irq_r, irq_nxt;
  logic [31:0] setp_r, setp_nxt;
  logic [15:0] faultPrev_r, faultPrev_nxt, emcyCode_r, emcyCode_nxt, sdoIdx_r, sdoIdx_nxt;
  logic [15:0] cw, sdoIdxIn;
  logic [7:0] sdoSub_r, sdoSub_nxt, emcyReg_r, emcyReg_nxt, sdoSubIn;
  logic [10:0] txId_r, txId_nxt, nodeOfs;
  logic [3:0] txDlc_r, txDlc_nxt;
  logic [63:0] txData_r, txData_nxt;
  logic isNmt, isSync, isSdo, isCw, isSetp;

  always_comb begin
    nodeOfs = {4'h0, nodeId_r};
    cw = rxData[15:0];
    sdoIdxIn = rxData[23:8];
    sdoSubIn = rxData[31:24];
    isNmt = rxValid && rxId == `DIPN_ID_NMT;
    isSync = rxValid && rxId == `DIPN_ID_SYNC && nmtOp_r;
    isSdo = rxValid && rxId == `DIPN_ID_SDO_RX + nodeOfs;
    isCw = rxValid && rxId == `DIPN_ID_RPDO1 + nodeOfs && nmtOp_r && rxDlc >= `DIPN_DLC_SW;
    isSetp = rxValid && rxId == `DIPN_ID_RPDO2 && nmtOp_r && rxDlc == `DIPN_DLC_FULL;
    {nodeId_nxt, slot_nxt, nmtOp_nxt, mode_nxt} = {nodeId_r, slot_r, nmtOp_r, mode_r};
    {ipUnit_nxt, ipExp_nxt, state_nxt, targetPos_nxt} = {ipUnit_r, ipExp_r, state_r, targetPos_r};
    {setpPend_nxt, sdoPend_nxt, stPend_nxt, pdoPend_nxt} = {setpPend_r, sdoPend_r, stPend_r, pdoPend_r};
    {emcyPend_nxt, sdoOk_nxt, setp_nxt, faultPrev_nxt} = {emcyPend_r, sdoOk_r, setp_r, faultPrev_r};
    {emcyCode_nxt, emcyReg_nxt, sdoIdx_nxt, sdoSub_nxt} = {emcyCode_r, emcyReg_r, sdoIdx_r, sdoSub_r};
    {txValid_nxt, txId_nxt, txDlc_nxt, txData_nxt} = {txValid_r, txId_r, txDlc_r, txData_r};
    irqMask_nxt = irqMask_r;
    step_nxt = 1'b0;
    ev = 4'h0;
    if (txValid_r && txReady) begin
      txValid_nxt = 1'b0;
    end
    // loader runs before the event code so that a new request wins over the clear
    if (!txValid_r) begin
      if (emcyPend_r) begin
        emcyPend_nxt = 1'b0;
        txId_nxt = `DIPN_ID_EMCY + nodeOfs;
        txData_nxt = {40'h0000000000, emcyReg_r, emcyCode_r};
      end else if (sdoPend_r) begin
        sdoPend_nxt = 1'b0;
        txId_nxt = `DIPN_ID_SDO_TX + nodeOfs;
        txData_nxt = sdoOk_r ? {32'h00000000, sdoSub_r, sdoIdx_r, `DIPN_SDO_ACK}
                             : {`DIPN_ABORT_CODE, sdoSub_r, sdoIdx_r, `DIPN_SDO_ABORT};
      end else if (stPend_r) begin
        stPend_nxt = 1'b0;
        txId_nxt = `DIPN_ID_TPDO + nodeOfs;
        txData_nxt = {48'h000000000000, swOf(state_r)};
      end else if (pdoPend_r) begin
        pdoPend_nxt = 1'b0;
        txId_nxt = `DIPN_ID_TPDO + nodeOfs;
        txData_nxt = {mfrStatus, actualPos};
      end
      txDlc_nxt = stPend_r && !emcyPend_r && !sdoPend_r ? `DIPN_DLC_SW : `DIPN_DLC_FULL;
      txValid_nxt = emcyPend_r || sdoPend_r || stPend_r || pdoPend_r;
    end
    if (isNmt && (rxData[15:8] == 8'h00 || rxData[15:8] == {1'b0, nodeId_r})) begin
      if (rxData[7:0] == `DIPN_NMT_START) begin
        nmtOp_nxt = 1'b1;
      end else if (rxData[7:0] == `DIPN_NMT_STOP || rxData[7:0] == `DIPN_NMT_PREOP) begin
        nmtOp_nxt = 1'b0;
      end
    end
    if (isSdo) begin
      sdoPend_nxt = 1'b1;
      sdoIdx_nxt = sdoIdxIn;
      sdoSub_nxt = sdoSubIn;
      sdoOk_nxt = 1'b0;
      ev[3] = 1'b1;
      if (rxData[7:0] == `DIPN_SDO_WR1) begin
        if (sdoIdxIn == `DIPN_OBJ_MODE && sdoSubIn == `DIPN_SUB_0) begin
          mode_nxt = rxData[39:32];
          sdoOk_nxt = 1'b1;
        end else if (sdoIdxIn == `DIPN_OBJ_IPTIME && sdoSubIn == `DIPN_SUB_1) begin
          ipUnit_nxt = rxData[39:32];
          sdoOk_nxt = 1'b1;
        end else if (sdoIdxIn == `DIPN_OBJ_IPTIME && sdoSubIn == `DIPN_SUB_2) begin
          ipExp_nxt = rxData[39:32];
          sdoOk_nxt = 1'b1;
        end
      end
    end
    if (isCw) begin
      stPend_nxt = 1'b1;
      // out-of-order words leave the state alone; master waits per step
      case (cw)
        `DIPN_CW_SHUTDOWN: if (state_r != dipn_pkg::ST_FAULT) state_nxt = dipn_pkg::ST_READY;
        `DIPN_CW_SWON: if (state_r == dipn_pkg::ST_READY || state_r == dipn_pkg::ST_OPEN ||
                           state_r == dipn_pkg::ST_IP) state_nxt = dipn_pkg::ST_SWON;
        `DIPN_CW_ENOP: if (state_r == dipn_pkg::ST_SWON || state_r == dipn_pkg::ST_IP)
                         state_nxt = dipn_pkg::ST_OPEN;
        `DIPN_CW_ENIP: if (state_r == dipn_pkg::ST_OPEN && mode_r == `DIPN_MODE_IP)
                         state_nxt = dipn_pkg::ST_IP;
        `DIPN_CW_FRESET: if (state_r == dipn_pkg::ST_FAULT && faultCode == 16'h0000)
                           state_nxt = dipn_pkg::ST_DISABLED;
        default: state_nxt = state_r;
      endcase
    end
    if (isSetp) begin
      setp_nxt = slot_r ? rxData[63:32] : rxData[31:0];
      setpPend_nxt = 1'b1;
      ev[1] = 1'b1;
    end
    if (isSync) begin
      pdoPend_nxt = 1'b1;
      ev[0] = 1'b1;
      if (setpPend_r && state_r == dipn_pkg::ST_IP) begin
        targetPos_nxt = setp_r;
        step_nxt = 1'b1;
        setpPend_nxt = 1'b0;
      end
    end
    if (faultCode != faultPrev_r) begin
      faultPrev_nxt = faultCode;
      emcyCode_nxt = faultCode;
      emcyReg_nxt = faultCode == 16'h0000 ? 8'h00 : errReg;
      emcyPend_nxt = 1'b1;
      ev[2] = 1'b1;
    end
    if (faultCode != 16'h0000) begin
      state_nxt = dipn_pkg::ST_FAULT;
    end
    ipCycUs_nxt = cycUs(ipUnit_r, ipExp_r);
    ipAct_nxt = state_nxt == dipn_pkg::ST_IP;
    if (wrEn && awAddr_r == `DIPN_REG_CTRL && wStrb_r[0]) nodeId_nxt = wData_r[6:0];
    if (wrEn && awAddr_r == `DIPN_REG_CTRL && wStrb_r[1]) slot_nxt = wData_r[8];
    if (wrEn && awAddr_r == `DIPN_REG_MASK) irqMask_nxt = wData_r[3:0] & wMask[3:0];
    irqStat_nxt = irqStat_r;
    if (wrEn && awAddr_r == `DIPN_REG_IRQ) irqStat_nxt = irqStat_r & ~(wData_r[3:0] & wMask[3:0]);
    irqStat_nxt = irqStat_nxt | ev;
    irq_nxt = |(irqStat_nxt & irqMask_nxt);
  end

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      {nodeId_r, slot_r, nmtOp_r, mode_r} <= {NODE_ID, 1'b0, 1'b0, 8'h00};
      {ipUnit_r, ipExp_r, ipCycUs_r} <= {`DIPN_UNIT_RST, `DIPN_EXP_MS, `DIPN_US_PER_MS};
      state_r <= dipn_pkg::ST_DISABLED;
      {targetPos_r, setp_r, setpPend_r, sdoPend_r} <= {64'h0000000000000000, 2'h0};
      {stPend_r, pdoPend_r, emcyPend_r, sdoOk_r} <= 4'h0;
      {faultPrev_r, emcyCode_r, emcyReg_r} <= 40'h0000000000;
      {sdoIdx_r, sdoSub_r, irqStat_r, irqMask_r} <= 32'h00000000;
      {txValid_r, txId_r, txDlc_r, txData_r} <= 80'h0;
      {step_r, ipAct_r, irq_r} <= 3'h0;
    end else begin
      {nodeId_r, slot_r, nmtOp_r, mode_r} <= {nodeId_nxt, slot_nxt, nmtOp_nxt, mode_nxt};
      {ipUnit_r, ipExp_r, ipCycUs_r} <= {ipUnit_nxt, ipExp_nxt, ipCycUs_nxt};
      state_r <= state_nxt;
      {targetPos_r, setp_r, setpPend_r, sdoPend_r} <= {targetPos_nxt, setp_nxt, setpPend_nxt, sdoPend_nxt};
      {stPend_r, pdoPend_r, emcyPend_r, sdoOk_r} <= {stPend_nxt, pdoPend_nxt, emcyPend_nxt, sdoOk_nxt};
      {faultPrev_r, emcyCode_r, emcyReg_r} <= {faultPrev_nxt, emcyCode_nxt, emcyReg_nxt};
      {sdoIdx_r, sdoSub_r, irqStat_r, irqMask_r} <= {sdoIdx_nxt, sdoSub_nxt, irqStat_nxt, irqMask_nxt};
      {txValid_r, txId_r, txDlc_r, txData_r} <= {txValid_nxt, txId_nxt, txDlc_nxt, txData_nxt};
      {step_r, ipAct_r, irq_r} <= {step_nxt, ipAct_nxt, irq_nxt};
    end
  end

  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} = {awready_r, wready_r, bvalid_r, bresp_r};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {arready_r, rvalid_r, rdata_r, rresp_r};
  assign {txValid, txId, txDlc, txData} = {txValid_r, txId_r, txDlc_r, txData_r};
  assign {targetPos, stepStrobe, ipActive, irq} = {targetPos_r, step_r, ipAct_r, irq_r};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_r);
  property p_mode; isSdo && rxData[7:0] == `DIPN_SDO_WR1 && sdoIdxIn == `DIPN_OBJ_MODE &&
    sdoSubIn == `DIPN_SUB_0 |=> mode_r == $past(rxData[39:32]) && sdoPend_r && sdoOk_r; endproperty
  a_mode: assert property (p_mode) else $error("mode write not taken");
  property p_cyc; ipUnit_r == `DIPN_UNIT_RST && ipExp_r == `DIPN_EXP_MS ##1 $stable(ipUnit_r) &&
    $stable(ipExp_r) |-> ipCycUs_r == `DIPN_US_PER_MS; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle not 1 ms");
  property p_noop; rxValid && rxId == `DIPN_ID_RPDO2 && !nmtOp_r |=> $stable(setp_r); endproperty
  a_noop: assert property (p_noop) else $error("setpoint taken while not operational");
  property p_ip; isCw && cw == `DIPN_CW_ENIP && state_r == dipn_pkg::ST_OPEN &&
    mode_r == `DIPN_MODE_IP && faultCode == 16'h0000 |=> ipActive && stPend_r; endproperty
  a_ip: assert property (p_ip) else $error("interpolation not enabled");
  property p_slot; isSetp && slot_r |=> setp_r == $past(rxData[63:32]) && setpPend_r; endproperty
  a_slot: assert property (p_slot) else $error("wrong setpoint slot");
  property p_step; stepStrobe |-> $past(isSync) && targetPos == $past(setp_r); endproperty
  a_step: assert property (p_step) else $error("step without sync");
  property p_sync; isSync |=> pdoPend_r ##[0:40] (txValid && txDlc == `DIPN_DLC_FULL &&
    txId == `DIPN_ID_TPDO + nodeOfs); endproperty
  a_sync: assert property (p_sync) else $error("sync gave no frame");
  property p_pdo; $fell(pdoPend_r) |-> txValid && txId == `DIPN_ID_TPDO + nodeOfs &&
    txData[31:0] == $past(actualPos); endproperty
  a_pdo: assert property (p_pdo) else $error("position frame wrong");
  property p_emcy; $changed(faultCode) |=> emcyPend_r ##[0:40] (txValid && txId ==
    `DIPN_ID_EMCY + nodeOfs); endproperty
  a_emcy: assert property (p_emcy) else $error("emergency not queued");
  property p_clr; $fell(|faultCode) |=> emcyPend_r && emcyCode_r == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("clear emergency missing");
  c_ip: cover property (isSync && state_r == dipn_pkg::ST_IP ##1 stepStrobe);
  c_emcy: cover property (txValid && txReady && txId == `DIPN_ID_EMCY + nodeOfs);
  c_abort: cover property (txValid && txData[7:0] == `DIPN_SDO_ABORT);
  c_irq: cover property ($rose(irq));
endmodule // dipn_node
`default_nettype wire

// >>> dv/dipn_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bus master model
// ****************************************
module dipn_master_model (
  input wire logic clk,
  output logic rxValid,
  output logic [10:0] rxId,
  output logic [3:0] rxDlc,
  output logic [63:0] rxData,
  input wire logic txValid,
  input wire logic [10:0] txId,
  input wire logic [3:0] txDlc,
  input wire logic [63:0] txData,
  output logic txReady
);
  logic timedOut;
  initial begin
    rxValid = 1'b0;
    rxId = 11'h7FF;
    rxDlc = 4'hF;
    rxData = 64'h0;
    txReady = 1'b0;
    timedOut = 1'b0;
  end
  task automatic sendFrame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk);
    rxValid <= 1'b1;
    rxId <= id;
    rxDlc <= dlc;
    rxData <= d;
    @(posedge clk);
    rxValid <= 1'b0;
    // idle id and data lines show the inverse so stale data never looks valid
    rxId <= ~id;
    rxData <= ~d;
  endtask
  task automatic takeFrame(input int slow, output logic [10:0] id, output logic [3:0] dlc,
      output logic [63:0] d);
    int n;
    // slow stalls the node before accepting; the reply is awaited after txReady rises
    repeat (slow + 1) @(posedge clk);
    txReady <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (txValid === 1'b1) break;
    end
    txReady <= 1'b0;
    timedOut = (n == 100);
    id = txId;
    dlc = txDlc;
    d = txData;
  endtask
endmodule // dipn_master_model
`default_nettype wire

// >>> dv/tb_drive_interpolated_position_node.sv
`timescale 1ns/1ns
`default_nettype none
`include "dipn_map.svh"
module tb_drive_interpolated_position_node;
  localparam logic [15:0] CWS [4] = '{16'h0006, 16'h0007, 16'h000F, 16'h001F};
  localparam logic [15:0] SWS [4] = '{16'h0231, 16'h0233, 16'h0237, 16'h1237};
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, rxDlc, txDlc;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rxValid, txValid, txReady, stepStrobe, ipActive, irq;
  logic [10:0] rxId, txId;
  logic [63:0] rxData, txData;
  logic [31:0] actualPos = 32'h123, mfrStatus = 32'h44030000, targetPos;
  logic [15:0] faultCode = 16'h0;
  logic [7:0] errReg = 8'h08;
  int errors = 0, samples_checked = 0;
  always #20 clk = ~clk;
  dipn_node dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxValid, .rxId, .rxDlc, .rxData, .txValid, .txId, .txDlc, .txData, .txReady,
    .actualPos, .mfrStatus, .faultCode, .errReg, .targetPos, .stepStrobe, .ipActive, .irq);
  dipn_master_model m (.clk, .rxValid, .rxId, .rxDlc, .rxData, .txValid, .txId, .txDlc,
    .txData, .txReady);
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tmo(input logic hit);
    if (hit) begin
      chk("answer wait", 64'h0, 64'h1);
      final_report();
    end
  endtask
  task automatic axWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n == 50);
  endtask
  task automatic axRd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n == 50);
  endtask
  task automatic frame(input int slow, input logic [10:0] id, input logic [3:0] dlc,
      input logic [63:0] d, input logic [63:0] msk);
    logic [10:0] gi;
    logic [3:0] gd;
    logic [63:0] g;
    m.takeFrame(slow, gi, gd, g);
    tmo(m.timedOut);
    chk("txId", 64'(id), 64'(gi));
    chk("txDlc", 64'(dlc), 64'(gd));
    chk("txData", d & msk, g & msk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk);
    tmo(1'b1);
  end
  initial begin
    logic [1:0] r;
    logic [31:0] q;
    int n;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axRd(`DIPN_REG_STAT, q, r);
    chk("stat", 64'h250, 64'(q));
    axRd(8'h20, q, r);
    chk("unmapped", 64'(`DIPN_RESP_SLVERR), 64'(r));
    axWr(`DIPN_REG_STAT, 32'h0, r);
    chk("read only", 64'(`DIPN_RESP_SLVERR), 64'(r));
    $display("test registers done");
    m.sendFrame(11'h601, 4'h8, 64'h00000007_0060602F);
    frame(0, 11'h581, 4'h8, 64'h00606060, '1);
    m.sendFrame(11'h601, 4'h8, 64'h00000001_0160C22F);
    frame(5, 11'h581, 4'h8, 64'h0160C260, '1);
    m.sendFrame(11'h601, 4'h8, 64'h000000FD_0260C22F);
    frame(0, 11'h581, 4'h8, 64'h0260C260, '1);
    axRd(`DIPN_REG_IPCYC, q, r);
    chk("cycle", 64'h3E8, 64'(q));
    m.sendFrame(11'h601, 4'h8, 64'h000000FC_0260C22F);
    frame(0, 11'h581, 4'h8, 64'h0260C260, '1);
    axRd(`DIPN_REG_IPCYC, q, r);
    chk("cycle 100us", 64'h64, 64'(q));
    m.sendFrame(11'h601, 4'h8, 64'h0012342F);
    frame(0, 11'h581, 4'h8, 64'h06020000_00123480, '1);
    $display("test configuration done");
    m.sendFrame(11'h301, 4'h8, 64'h1);
    m.sendFrame(11'h080, 4'h0, 64'h0);
    axRd(`DIPN_REG_IRQ, q, r);
    chk("not operational", 64'h8, 64'(q));
    m.sendFrame(11'h000, 4'h2, 64'h0001);
    axRd(`DIPN_REG_STAT, q, r);
    chk("operational", 64'h1, 64'(q[16]));
    for (int i = 0; i < 4; i++) begin
      m.sendFrame(11'h201, 4'h2, 64'(CWS[i]));
      frame(i, 11'h181, 4'h2, 64'(SWS[i]), 64'hFFFF);
    end
    chk("ipActive", 64'h1, 64'(ipActive));
    $display("test state walk done");
    axWr(`DIPN_REG_MASK, 32'hF, r);
    for (int s = 0; s < 2; s++) begin
      axWr(`DIPN_REG_CTRL, {23'h0, s[0], 8'h01}, r);
      m.sendFrame(11'h301, 4'h8, 64'h000003E8_000001F4);
      repeat (4) @(posedge clk);
      chk("held", s ? 64'h1F4 : 64'h0, 64'(targetPos));
      m.sendFrame(11'h080, 4'h0, 64'h0);
      for (n = 0; n < 20 && stepStrobe !== 1'b1; n++) @(posedge clk);
      tmo(n == 20);
      chk("targetPos", s ? 64'h3E8 : 64'h1F4, 64'(targetPos));
      frame(s * 3, 11'h181, 4'h8, {mfrStatus, actualPos}, '1);
    end
    chk("irq raised", 64'h1, 64'(irq));
    axRd(`DIPN_REG_IRQ, q, r);
    chk("irq status", 64'hB, 64'(q));
    axWr(`DIPN_REG_IRQ, 32'hF, r);
    axWr(`DIPN_REG_MASK, 32'h0, r);
    axRd(`DIPN_REG_IRQ, q, r);
    chk("irq cleared", 64'h0, {63'h0, irq} | 64'(q));
    $display("test setpoints done");
    faultCode <= 16'h4310;
    frame(2, 11'h081, 4'h8, 64'h00084310, '1);
    axRd(`DIPN_REG_IRQ, q, r);
    chk("irq masked", 64'h4, {63'h0, irq} | 64'(q));
    axWr(`DIPN_REG_MASK, 32'h4, r);
    axRd(`DIPN_REG_IRQ, q, r);
    chk("irq unmasked", 64'h1, 64'(irq));
    faultCode <= 16'h0;
    frame(0, 11'h081, 4'h8, 64'h0, '1);
    m.sendFrame(11'h201, 4'h2, 64'h0080);
    frame(0, 11'h181, 4'h2, 64'h0250, 64'hFFFF);
    m.sendFrame(11'h000, 4'h2, 64'h0102);
    axRd(`DIPN_REG_STAT, q, r);
    chk("stopped", 64'h0250, 64'(q[16:0]));
    $display("test faults done");
    final_report();
  end
endmodule // tb_drive_interpolated_position_node
`default_nettype wire
